// File: include/bmxa_pkg.sv
// bmxa_pkg: constants and types shared by both ends of the bus exchange link.
// assumes: a 25 MHz constant clock and a bus clock of at most 10 MHz.
package bmxa_pkg;

  // constant clock and bus clock timing
  localparam int MCLK_PERIOD_NS     = 40;
  localparam int BCLK_MIN_PERIOD_NS = 100;   // fastest bus clock, 10 MHz
  // half period of the generated bus clock in constant clock cycles, rounded up
  localparam int BCLK_HALF_CYCLES   =
    (BCLK_MIN_PERIOD_NS + 2 * MCLK_PERIOD_NS - 1) / (2 * MCLK_PERIOD_NS);

  // parallel resolver limit and default placement of the exchanging master
  localparam int MAX_MASTERS     = 16;
  localparam int DEF_DEV_SLOT    = 1;

  // synchroniser depth
  localparam int SYNC_STAGES     = 2;

  // values after reset of the active-low exchange lines and their active-high pull enables, all inactive
  localparam logic LINE_IDLE     = 1'b1;
  localparam logic OE_OFF        = 1'b0;

  // exchange state of one master
  typedef enum logic [1:0]
  {
    BMXA_IDLE = 2'h0,
    BMXA_REQ  = 2'h1,
    BMXA_OWN  = 2'h2
  } bmxa_state_type;

endpackage : bmxa_pkg

// File: include/bmxa_link_if.sv
// bmxa_link_if: the exchange lines between one master and the rest of the system.
// assumes: open-collector lines are resolved here from each party's enables.
`timescale 1ns/1ps
interface bmxa_link_if;
  logic bus_clk;               // bus clock, made by the system end
  logic busy_n_m_o;            // busy, master end drive value
  logic busy_n_m_oe;           // busy, master end pulls low
  logic busy_n_s_o;            // busy, system end drive value
  logic busy_n_s_oe;           // busy, system end pulls low
  logic busy_n;                // resolved busy line
  logic shared_request_line_n_m_o;
  logic shared_request_line_n_m_oe;
  logic shared_request_line_n_s_o;
  logic shared_request_line_n_s_oe;
  logic shared_request_line_n; // resolved shared request line
  logic priority_in_n;         // to the master
  logic priority_out_n;        // from the master
  logic bus_request_line_n;    // from the master
  logic drivers_enable;        // master's address, data, command drivers on

  // open-collector wired-and of both parties
  assign busy_n = ~((busy_n_m_oe & ~busy_n_m_o) | (busy_n_s_oe & ~busy_n_s_o));
  assign shared_request_line_n =
    ~((shared_request_line_n_m_oe & ~shared_request_line_n_m_o) |
      (shared_request_line_n_s_oe & ~shared_request_line_n_s_o));

  modport master
  (
    input  bus_clk, busy_n, shared_request_line_n, priority_in_n,
    output busy_n_m_o, busy_n_m_oe, shared_request_line_n_m_o,
    output shared_request_line_n_m_oe, priority_out_n, bus_request_line_n,
    output drivers_enable
  );

  modport system
  (
    input  busy_n, shared_request_line_n, priority_out_n, bus_request_line_n,
    input  drivers_enable,
    output bus_clk, busy_n_s_o, busy_n_s_oe, shared_request_line_n_s_o,
    output shared_request_line_n_s_oe, priority_in_n
  );
endinterface : bmxa_link_if

// File: logic/bmxa_sync2.sv
// bmxa_sync2: two flip-flop synchroniser for a group of levels.
// assumes: each bit is a level that holds for several destination clocks.
`timescale 1ns/1ps
module bmxa_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_d,
  output logic      [WIDTH-1:0] o_q
);
  import bmxa_pkg::*;

  logic [WIDTH-1:0] meta;

  if (WIDTH < 1)
  begin : g_bad_width
    $error("bmxa_sync2: WIDTH must be at least 1");
  end

  // first stage feeds only the second stage
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      meta <= '0;
      o_q  <= '0;
    end
    else
    begin
      meta <= i_d;
      o_q  <= meta;
    end
  end
endmodule : bmxa_sync2

// File: logic/bmxa_master_end.sv
// bmxa_master_end: bus exchange logic of one master on a shared bus.
// assumes: local requests come on the constant clock; the exchange side runs on
// the falling edge of the bus clock, which may be slowed, stepped or stopped.
`timescale 1ns/1ps

// Contract
// R1: exchange lines sampled, changed on bus clock fall
// R2: works at any bus clock rate, even stopped
// R3: local side asynchronous to the bus clock
// R4: only the owner pulls busy low
// R5: take bus only with priority in active
// R6: requesting master drives priority out inactive
// R7: system ties top priority in, chains outputs
// R8: serial mode keeps bus request internal
// R9: parallel request line, resolver grants one master
// R10: waiting master pulls shared request line
// R11: owner keeps bus while shared request idle
// R12: local need registered before external request
// R13: lost priority: finish command, then drop busy
// R14: drivers disabled together with busy release
// R15: priority and free bus: take busy, drivers
// R16: lock keeps busy regardless of priority
// R17: idle serial master passes priority through
// R18: reset withdraws request, busy and drivers
module bmxa_master_end (
  input  wire logic i_mclk,
  input  wire logic i_rst,
  input  wire logic i_need,
  input  wire logic i_lock,
  input  wire logic i_cmd_active,
  input  wire logic i_serial_mode,
  output logic      o_owner,
  output logic      o_requesting,
  bmxa_link_if.master link
);
  import bmxa_pkg::*;

  logic           bus_fall_clk;
  logic [3:0]     local_sync;
  logic           s_need;
  logic           s_lock;
  logic           s_cmd;
  logic           s_serial;
  logic           prio_ok;
  logic           bus_free;
  logic           others_wait;
  logic           need_reg;
  logic           owned;
  bmxa_state_type state;
  bmxa_state_type next_state;

  // the synchroniser clocks on its rising edge, so give it the inverted bus clock
  assign bus_fall_clk = ~link.bus_clk; // R1

  // local levels enter the bus domain through two flops each
  bmxa_sync2 #(
    .WIDTH (4)
  ) u_local_sync (
    .i_clk (bus_fall_clk),
    .i_rst (i_rst),
    .i_d   ({i_need, i_lock, i_cmd_active, i_serial_mode}),
    .o_q   (local_sync)
  ); // R3

  assign s_need   = local_sync[3];
  assign s_lock   = local_sync[2];
  assign s_cmd    = local_sync[1];
  assign s_serial = local_sync[0];

  // exchange lines are synchronous to the bus clock and sampled as they stand
  assign prio_ok     = ~link.priority_in_n;
  assign bus_free    = link.busy_n;
  assign others_wait = ~link.shared_request_line_n;

  // need is captured on a falling edge before it is shown as a request
  always_ff @(negedge link.bus_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      need_reg <= 1'b0;
    end
    else
    begin
      need_reg <= s_need; // R12
    end
  end

  // next exchange state
  always_comb
  begin
    next_state = state;
    case (state)
      BMXA_IDLE:
      begin
        if (need_reg)
        begin
          next_state = BMXA_REQ;
        end
      end
      BMXA_REQ:
      begin
        if (!need_reg)
        begin
          next_state = BMXA_IDLE;
        end
        else if (prio_ok && bus_free)
        begin
          next_state = BMXA_OWN; // R5 R15
        end
      end
      BMXA_OWN:
      begin
        if (s_lock)
        begin
          next_state = BMXA_OWN; // R16
        end
        else if (s_cmd)
        begin
          next_state = BMXA_OWN; // R13
        end
        else if (!prio_ok)
        begin
          next_state = BMXA_IDLE; // R13
        end
        else if (!need_reg && others_wait)
        begin
          next_state = BMXA_IDLE; // R11
        end
      end
      default:
      begin
        next_state = BMXA_IDLE;
      end
    endcase
  end

  // exchange state register
  always_ff @(negedge link.bus_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state <= BMXA_IDLE; // R18
    end
    else
    begin
      state <= next_state; // R1
    end
  end

  // busy and the bus drivers switch together on the owning edge
  always_ff @(negedge link.bus_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      link.busy_n_m_oe    <= OE_OFF; // R18
      link.drivers_enable <= 1'b0;
      owned               <= 1'b0;
    end
    else
    begin
      link.busy_n_m_oe    <= (next_state == BMXA_OWN); // R4 R15 R13
      link.drivers_enable <= (next_state == BMXA_OWN); // R14
      owned               <= (next_state == BMXA_OWN);
    end
  end

  // open-collector lines only ever pull low
  assign link.busy_n_m_o                = 1'b0;
  assign link.shared_request_line_n_m_o = 1'b0;

  // a waiting master pulls the shared request line
  always_ff @(negedge link.bus_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      link.shared_request_line_n_m_oe <= OE_OFF;
    end
    else
    begin
      link.shared_request_line_n_m_oe <= (next_state == BMXA_REQ); // R10
    end
  end

  // request line used only by the parallel resolver
  always_ff @(negedge link.bus_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      link.bus_request_line_n <= LINE_IDLE; // R18
    end
    else if (s_serial)
    begin
      link.bus_request_line_n <= LINE_IDLE; // R8
    end
    else
    begin
      link.bus_request_line_n <= ~need_reg; // R9 R12
    end
  end

  // daisy chain output: blocked in parallel mode or while requesting, passed through otherwise
  always_ff @(negedge link.bus_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      link.priority_out_n <= LINE_IDLE;
    end
    else if (!s_serial)
    begin
      link.priority_out_n <= LINE_IDLE; // R9
    end
    else if (s_need || need_reg)
    begin
      link.priority_out_n <= LINE_IDLE; // R6
    end
    else
    begin
      link.priority_out_n <= link.priority_in_n; // R17
    end
  end

  // ownership and request status back to the local side
  bmxa_sync2 #(
    .WIDTH (2)
  ) u_status_sync (
    .i_clk (i_mclk),
    .i_rst (i_rst),
    .i_d   ({owned, need_reg}),
    .o_q   ({o_owner, o_requesting})
  ); // R2 R3

endmodule : bmxa_master_end

// File: logic/bmxa_system_end.sv
// bmxa_system_end: bus clock source, other masters and the priority resolver.
// assumes: all logic on the constant clock; the bus clock is divided from it.
`timescale 1ns/1ps
module bmxa_system_end #(
  parameter int NUM_MASTERS = bmxa_pkg::MAX_MASTERS,
  parameter int DEV_SLOT    = bmxa_pkg::DEF_DEV_SLOT
) (
  input  wire logic                   i_mclk,
  input  wire logic                   i_rst,
  input  wire logic                   i_serial_mode,
  input  wire logic [NUM_MASTERS-1:0] i_req,
  input  wire logic                   i_other_busy,
  input  wire logic                   i_other_shared,
  output logic      [NUM_MASTERS-1:0] o_grant,
  output logic                        o_busy,
  output logic                        o_dev_request,
  output logic                        o_dev_prio_out,
  bmxa_link_if.system link
);
  import bmxa_pkg::*;

  localparam int CNT_W = $clog2(2 * BCLK_HALF_CYCLES);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(2 * BCLK_HALF_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_FALL = CNT_W'(BCLK_HALF_CYCLES);

  logic [CNT_W-1:0]       cnt;
  logic [NUM_MASTERS-1:0] next_grant;
  logic [NUM_MASTERS-1:0] all_req;

  if (NUM_MASTERS < 1 || NUM_MASTERS > MAX_MASTERS || DEV_SLOT >= NUM_MASTERS)
  begin : g_bad_cfg
    $error("bmxa_system_end: NUM_MASTERS 1..16 and DEV_SLOT below it");
  end

  // grant for serial chain or parallel resolver; parallel parks on no request
  function automatic logic [NUM_MASTERS-1:0] pick_grant(
    input logic [NUM_MASTERS-1:0] req,
    input logic                   serial,
    input logic                   dev_pass,
    input logic [NUM_MASTERS-1:0] last
  );
    logic [NUM_MASTERS-1:0] g;
    logic                   chain;
    g     = '0;
    chain = 1'b1; // R7
    for (int i = 0; i < NUM_MASTERS; i++)
    begin
      if (serial)
      begin
        g[i]  = chain;
        chain = (i == DEV_SLOT) ? (chain & dev_pass) : (chain & ~req[i]);
      end
      else if (chain && req[i])
      begin
        g[i]  = 1'b1;
        chain = 1'b0;
      end
    end
    if (!serial && chain)
    begin
      g = last;
    end
    return g;
  endfunction : pick_grant

  // bus clock divider; high for the first half period
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt          <= '0;
      link.bus_clk <= 1'b1;
    end
    else
    begin
      cnt          <= (cnt == CNT_LAST) ? '0 : cnt + 1'b1;
      link.bus_clk <= (cnt == CNT_LAST) || (cnt < CNT_FALL - 1'b1);
    end
  end

  // sample the master's lines at the falling edge
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_busy         <= 1'b0;
      o_dev_request  <= 1'b0;
      o_dev_prio_out <= 1'b0;
    end
    else if (cnt == CNT_FALL - 1'b1)
    begin
      o_busy         <= ~link.busy_n;
      o_dev_request  <= ~link.bus_request_line_n;
      o_dev_prio_out <= ~link.priority_out_n;
    end
  end

  // request vector with the master's own request in its slot
  always_comb
  begin
    all_req           = i_req;
    all_req[DEV_SLOT] = o_dev_request;
    next_grant        = pick_grant(all_req, i_serial_mode, o_dev_prio_out, o_grant);
  end

  // drive grant and the other masters' lines one clock after the fall
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_grant                         <= '0;
      link.priority_in_n              <= LINE_IDLE;
      link.busy_n_s_oe                <= OE_OFF;
      link.shared_request_line_n_s_oe <= OE_OFF;
    end
    else if (cnt == CNT_FALL)
    begin
      o_grant                         <= next_grant;
      link.priority_in_n              <= ~next_grant[DEV_SLOT];
      link.busy_n_s_oe                <= i_other_busy;
      link.shared_request_line_n_s_oe <= i_other_shared;
    end
  end

  assign link.busy_n_s_o                = 1'b0;
  assign link.shared_request_line_n_s_o = 1'b0;

endmodule : bmxa_system_end

// File: tb/bmxa_link_properties.sv
// bmxa_link_properties: timing checks on the exchange lines of one master.
// assumes: tb_top instances it beside the link interface and feeds its signals.
`timescale 1ns/1ps
module bmxa_link_properties (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic bus_clk,
  input wire logic busy_n,
  input wire logic busy_n_m_oe,
  input wire logic shared_request_line_n,
  input wire logic shared_request_line_n_m_oe,
  input wire logic priority_in_n,
  input wire logic priority_out_n,
  input wire logic bus_request_line_n,
  input wire logic drivers_enable
);
  // bus free while this master holds priority
  sequence grant_free_s;
    !priority_in_n && busy_n;
  endsequence
  // owner with priority and no one waiting
  sequence park_s;
    busy_n_m_oe && shared_request_line_n && !priority_in_n;
  endsequence

  // low until the first bus clock fall after reset, so $past never looks across a reset
  logic settled;
  always_ff @(negedge bus_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      settled <= 1'b0;
    end
    else
    begin
      settled <= 1'b1;
    end
  end

  // master lines move only with a bus clock fall
  edge_sync_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    $changed({busy_n_m_oe, shared_request_line_n_m_oe, priority_out_n,
      bus_request_line_n, drivers_enable}) |-> $fell(bus_clk))
    else $error("master line moved off a bus clock fall");
  take_guard_a: assert property (@(negedge bus_clk) disable iff (i_rst)
    $rose(busy_n_m_oe) |-> $past(!priority_in_n && busy_n))
    else $error("busy taken without priority on a free bus");
  drive_pair_a: assert property (@(negedge bus_clk) disable iff (i_rst)
    busy_n_m_oe == drivers_enable)
    else $error("drivers and busy out of step");
  park_keep_a: assert property (@(negedge bus_clk) disable iff (i_rst)
    park_s |=> busy_n_m_oe)
    else $error("bus dropped with nobody waiting");
  release_cause_a: assert property (@(negedge bus_clk) disable iff (i_rst)
    settled && $fell(busy_n_m_oe) |-> $past(priority_in_n || !shared_request_line_n))
    else $error("bus dropped without cause");
  owner_share_a: assert property (@(negedge bus_clk) disable iff (i_rst)
    busy_n_m_oe |-> !shared_request_line_n_m_oe)
    else $error("owner pulls shared request");
  req_prio_a: assert property (@(negedge bus_clk) disable iff (i_rst)
    shared_request_line_n_m_oe |-> priority_out_n)
    else $error("waiting master passes priority on");
  line_mode_a: assert property (@(negedge bus_clk) disable iff (i_rst)
    !bus_request_line_n |-> priority_out_n)
    else $error("request line and priority out both active");
  reset_idle_a: assert property (@(posedge i_mclk)
    i_rst && $past(i_rst) |-> !busy_n_m_oe && !drivers_enable &&
      bus_request_line_n && !shared_request_line_n_m_oe)
    else $error("master lines active in reset");
  take_c: cover property (@(negedge bus_clk) disable iff (i_rst)
    grant_free_s ##1 busy_n_m_oe);
endmodule : bmxa_link_properties

// File: tb/tb_top.sv
// tb_top: drives both user sides of the exchange link and judges the results.
// assumes: the system end divides the bus clock from i_mclk.
`timescale 1ns/1ps
module tb_top;
  import bmxa_pkg::*;
  localparam int S = DEF_DEV_SLOT;
  logic                   i_mclk, i_rst, need, lock, cmd, serial, o_bsy, o_shr;
  logic [MAX_MASTERS-1:0] req, grant;
  logic                   owner, s_busy, d_prio, reqst, d_req;
  int                     err_total, check_count, cycles;
  bmxa_link_if link ();

  // the two ends facing each other
  bmxa_master_end i_bmxa_master_end (.i_mclk(i_mclk), .i_rst(i_rst), .i_need(need),
    .i_lock(lock), .i_cmd_active(cmd), .i_serial_mode(serial), .o_owner(owner),
    .o_requesting(reqst), .link(link));
  bmxa_system_end i_bmxa_system_end (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_serial_mode(serial), .i_req(req), .i_other_busy(o_bsy), .i_other_shared(o_shr),
    .o_grant(grant), .o_busy(s_busy), .o_dev_request(d_req), .o_dev_prio_out(d_prio),
    .link(link));
  bmxa_link_properties i_bmxa_link_properties (.i_mclk(i_mclk), .i_rst(i_rst),
    .bus_clk(link.bus_clk), .busy_n(link.busy_n), .busy_n_m_oe(link.busy_n_m_oe),
    .shared_request_line_n(link.shared_request_line_n),
    .shared_request_line_n_m_oe(link.shared_request_line_n_m_oe),
    .priority_in_n(link.priority_in_n), .priority_out_n(link.priority_out_n),
    .bus_request_line_n(link.bus_request_line_n),
    .drivers_enable(link.drivers_enable));

  // constant clock and hang limit
  always #20 i_mclk = ~i_mclk;
  always @(posedge i_mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_total++;
      finish_test();
    end
  end

  task automatic chk(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : step
  // bounded wait for the owner flag
  task automatic wait_own(input logic v);
    int n;
    n = 0;
    while (owner !== v && n < 120)
    begin
      step(1);
      n++;
    end
    chk("owner", v, owner);
  endtask : wait_own

  task automatic t_take;
    need = 1'b1;
    step(1);
    chk("early request", 1'b1, link.bus_request_line_n);
    wait_own(1'b1);
    // the system end samples busy only at the next bus clock fall
    step(4);
    chk("busy", 1'b1, s_busy);
    chk("requesting", 1'b1, reqst);
    chk("dev request", 1'b1, d_req);
    chk("grant", 1'b1, grant[S]);
    chk("request line", 1'b0, link.bus_request_line_n);
    chk("prio out", 1'b0, d_prio);
  endtask : t_take
  task automatic t_park;
    need = 1'b0;
    step(40);
    chk("parked", 1'b1, owner);
    chk("requesting", 1'b0, reqst);
    o_shr = 1'b1;
    wait_own(1'b0);
    chk("drivers", 1'b0, link.drivers_enable);
    o_shr = 1'b0;
  endtask : t_park
  task automatic t_wait;
    o_bsy = 1'b1;
    need = 1'b1;
    step(40);
    chk("owner", 1'b0, owner);
    chk("shared", 1'b0, link.shared_request_line_n);
    o_bsy = 1'b0;
    wait_own(1'b1);
  endtask : t_wait
  // higher master asks while a command or a lock holds the bus
  task automatic t_preempt(input logic use_lock);
    cmd = ~use_lock;
    lock = use_lock;
    // let the hold reach the bus side before priority is taken away
    step(12);
    req[0] = 1'b1;
    step(40);
    chk("held", 1'b1, owner);
    chk("grant", 1'b0, grant[S]);
    cmd = 1'b0;
    lock = 1'b0;
    wait_own(1'b0);
    chk("drivers", 1'b0, link.drivers_enable);
    step(40);
    chk("no priority", 1'b0, owner);
    req[0] = 1'b0;
    wait_own(1'b1);
  endtask : t_preempt
  task automatic t_reset;
    i_rst = 1'b1;
    serial = 1'b1;
    step(8);
    chk("owner", 1'b0, owner);
    chk("busy line", 1'b1, link.busy_n);
    chk("drivers", 1'b0, link.drivers_enable);
    i_rst = 1'b0;
  endtask : t_reset
  task automatic t_serial;
    wait_own(1'b1);
    chk("top grant", 1'b1, grant[0]);
    chk("request line", 1'b1, link.bus_request_line_n);
    chk("dev request", 1'b0, d_req);
    chk("prio out", 1'b0, d_prio);
    need = 1'b0;
    o_shr = 1'b1;
    wait_own(1'b0);
    step(12);
    chk("pass through", 1'b1, d_prio);
  endtask : t_serial

  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test

  // main sequence
  initial
  begin
    {i_mclk, need, lock, cmd, serial, o_bsy, o_shr} = '0;
    {req, err_total, check_count, cycles} = '0;
    i_rst = 1'b1;
    step(8);
    i_rst = 1'b0;
    t_take();
    t_park();
    t_wait();
    t_preempt(1'b0);
    t_preempt(1'b1);
    t_reset();
    t_serial();
    finish_test();
  end
endmodule : tb_top
